// ---- src/bus_size_wait_defines.vh ----
// Constants for the area bus width and wait-state controller.
// Assumes inclusion by bare name from the design files under src/.
`ifndef BUS_SIZE_WAIT_DEFINES_VH
`define BUS_SIZE_WAIT_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define AREA0_CTRL_ADDR   8'h68
`define AREA1_CTRL_ADDR   8'h69
`define AREA2_CTRL_ADDR   8'h6A
`define AREA3_CTRL_ADDR   8'h6B
`define UNMATCH_CTRL_ADDR 8'h6C
`define ADDR_W            8

// ****************************************
// Field positions
// ****************************************
`define ENABLE_BIT      4
`define STROBE_TYPE_BIT 3
`define WIDTH_SEL_BIT   2
`define WAIT_HI_BIT     1
`define WAIT_LO_BIT     0
`define FULL_RANGE_BIT  5

// ****************************************
// Reset values
// ****************************************
`define AREA0_CTRL_RST   8'h00
`define AREA1_CTRL_RST   8'h00
`define AREA2_CTRL_RST   8'h10
`define AREA3_CTRL_RST   8'h00
`define UNMATCH_CTRL_RST 8'h00

// ****************************************
// Wait modes and counts
// ****************************************
`define WAIT_TWO      2'h0
`define WAIT_ONE      2'h1
`define WAIT_ONE_PIN  2'h2
`define WAIT_NONE     2'h3
`define WAIT_CNT_W    2

// ****************************************
// Full-range window of area 2
// ****************************************
`define AREA2_RANGE_LO 24'h000080
`define AREA2_RANGE_HI 24'hFFFFFF

`endif

// ---- src/wait_sync.v ----
// Two-flop synchroniser for the external wait-request pin.
// Assumes the pin may change at any time relative to sys_clk.
`timescale 1ns/1ns
`default_nettype none

module wait_sync (
  // Clock and reset
  input  wire sys_clk,
  input  wire rst_b,
  // Pin and synchronised level
  input  wire pin_in,
  output wire pin_sync
);

  reg meta_q;
  reg sync_q;

  // The pin idles high (ready), so both flops reset to one.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;

endmodule

`default_nettype wire

// ---- src/bus_size_wait_control.v ----
// Area bus width and wait-state controller with its write-only registers.
// Assumes external comparators supply per-area address matches, and a bus
// sequencer that raises cycle_start once per external bus cycle.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "bus_size_wait_defines.vh"

// Functional notes
// - Four areas with select, wait, width control
// - Bit 4 enables each area
// - Reset: area 2 enabled, others off
// - Bit 2 picks 8 or 16 bit
// - Width pin high forces eight-bit accesses
// - Mode 00 adds two wait states
// - Mode 01 adds one wait state
// - Mode 10: one wait, then pin-extended
// - Mode 11 adds no wait states
// - Reset clears all wait fields
// - Refresh collision adds refresh on top
// - Area 3 bit 3 selects column strobe
// - Area 2 mode bit clear selects full range
// - Unmatched accesses use catch-all register
// - Lowest-numbered matching area wins
module bus_size_wait_control #(
  parameter REFRESH_STATES = 3
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // Access description
  input  wire [23:0] bus_addr,
  input  wire [3:0]  area_match,
  input  wire        cycle_start,
  input  wire        dram_access,
  input  wire        refresh_collide,
  // Pins
  input  wire        ext_width_select_pin,
  input  wire        wait_req_b,
  // Decoded access
  output reg  [3:0]  select_out_b,
  output reg         area3_cas_mode,
  output reg         width_8bit,
  output reg  [1:0]  wait_mode,
  output wire        wait_active,
  output wire        cycle_done
);

  // ****************************************
  // Write-only control registers
  // ****************************************
  reg [7:0] area_ctrl_q [0:3];
  reg [7:0] unmatch_ctrl_q;

  // Writes replace the whole register; there is no read path to merge.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Only area 2 comes up enabled; every wait field starts at 00.
      area_ctrl_q[0] <= `AREA0_CTRL_RST;
      area_ctrl_q[1] <= `AREA1_CTRL_RST;
      area_ctrl_q[2] <= `AREA2_CTRL_RST;
      area_ctrl_q[3] <= `AREA3_CTRL_RST;
      unmatch_ctrl_q <= `UNMATCH_CTRL_RST;
    end else if (reg_wr) begin
      if (reg_addr == `AREA0_CTRL_ADDR) begin
        area_ctrl_q[0] <= reg_wdata;
      end else if (reg_addr == `AREA1_CTRL_ADDR) begin
        area_ctrl_q[1] <= reg_wdata;
      end else if (reg_addr == `AREA2_CTRL_ADDR) begin
        area_ctrl_q[2] <= reg_wdata;
      end else if (reg_addr == `AREA3_CTRL_ADDR) begin
        area_ctrl_q[3] <= reg_wdata;
      end else if (reg_addr == `UNMATCH_CTRL_ADDR) begin
        unmatch_ctrl_q <= reg_wdata;
      end
    end
  end

  // Registers are write-only: every read returns zero.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Area hit and priority
  // ****************************************
  wire [3:0] area_hit;
  wire       area2_in_range;

  // The top bound is the end of the 24-bit space, so only the lower
  // bound really narrows the window.
  assign area2_in_range = (bus_addr >= `AREA2_RANGE_LO) && (bus_addr <= `AREA2_RANGE_HI);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_hit
      if (gi == 2) begin : g_a2
        // Mode bit clear: area 2 covers the full window.
        assign area_hit[gi] = area_ctrl_q[gi][`ENABLE_BIT] &&
          (area_ctrl_q[gi][`FULL_RANGE_BIT] ? area_match[gi] : area2_in_range);
      end else begin : g_ax
        assign area_hit[gi] = area_ctrl_q[gi][`ENABLE_BIT] && area_match[gi];
      end
    end
  endgenerate

  // Returns the lowest-numbered hit as an index, 3'h4 when none.
  function [2:0] first_hit;
    input [3:0] hits;
    begin
      if (hits[0]) begin
        first_hit = 3'h0;
      end else if (hits[1]) begin
        first_hit = 3'h1;
      end else if (hits[2]) begin
        first_hit = 3'h2;
      end else if (hits[3]) begin
        first_hit = 3'h3;
      end else begin
        first_hit = 3'h4;
      end
    end
  endfunction

  wire [2:0] sel_idx;
  reg  [7:0] sel_ctrl;

  assign sel_idx = first_hit(area_hit);

  always @* begin
    if (sel_idx[2]) begin
      sel_ctrl = unmatch_ctrl_q;
    end else begin
      sel_ctrl = area_ctrl_q[sel_idx[1:0]];
    end
  end

  // ****************************************
  // Registered decode outputs
  // ****************************************
  // Outputs lag the settings by one clock, so a write shows one edge
  // after the edge that stores it.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      select_out_b   <= 4'hF;
      area3_cas_mode <= 1'b0;
      width_8bit     <= 1'b0;
      wait_mode      <= `WAIT_TWO;
    end else begin
      if (sel_idx[2]) begin
        select_out_b <= 4'hF;
      end else begin
        select_out_b <= ~(4'h1 << sel_idx[1:0]);
      end
      area3_cas_mode <= area_ctrl_q[3][`STROBE_TYPE_BIT];
      // The pin overrides every width bit.
      width_8bit <= ext_width_select_pin | sel_ctrl[`WIDTH_SEL_BIT];
      wait_mode  <= sel_ctrl[`WAIT_HI_BIT:`WAIT_LO_BIT];
    end
  end

  // ****************************************
  // Wait-state sequencer
  // ****************************************
  // A start is heard only in idle; one that arrives while a cycle runs is
  // dropped, so the bus sequencer must wait for cycle_done.
  localparam ST_IDLE    = 2'h0;
  localparam ST_WAIT    = 2'h1;
  localparam ST_PIN     = 2'h2;
  localparam ST_REFRESH = 2'h3;

  wire wait_req_sync;

  // The pin idles high through its pull-up, so the synchroniser resets to one.
  wait_sync u_wait_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .pin_in   (wait_req_b),
    .pin_sync (wait_req_sync)
  );

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  reg [1:0] run_mode_q;
  reg [1:0] run_mode_d;
  reg       refresh_q;
  reg       refresh_d;
  // The refresh length is a parameter because the refresh timer sits
  // outside this block.
  reg [7:0] ref_cnt_q;
  reg [7:0] ref_cnt_d;
  reg       done;

  wire [1:0] start_mode;
  assign start_mode = sel_ctrl[`WAIT_HI_BIT:`WAIT_LO_BIT];

  always @* begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    run_mode_d = run_mode_q;
    refresh_d  = refresh_q;
    ref_cnt_d  = ref_cnt_q;
    done       = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (cycle_start) begin
          run_mode_d = start_mode;
          refresh_d  = dram_access & refresh_collide;
          if (start_mode == `WAIT_TWO) begin
            cnt_d   = 2'h2;
            state_d = ST_WAIT;
          end else if (start_mode == `WAIT_NONE) begin
            cnt_d = 2'h0;
            if (dram_access & refresh_collide) begin
              ref_cnt_d = REFRESH_STATES[7:0];
              state_d   = ST_REFRESH;
            end else begin
              done = 1'b1;
            end
          end else begin
            cnt_d   = 2'h1;
            state_d = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // The last fixed wait decides whether the pin may stretch the cycle.
        if (cnt_q > 2'h1) begin
          cnt_d = cnt_q - 2'h1;
        end else if ((run_mode_q == `WAIT_ONE_PIN) && !wait_req_sync) begin
          state_d = ST_PIN;
        end else if (refresh_q) begin
          ref_cnt_d = REFRESH_STATES[7:0];
          state_d   = ST_REFRESH;
        end else begin
          state_d = ST_IDLE;
          done    = 1'b1;
        end
      end
      ST_PIN: begin
        // Pin is sampled at the end of each extra wait state.
        if (wait_req_sync) begin
          if (refresh_q) begin
            ref_cnt_d = REFRESH_STATES[7:0];
            state_d   = ST_REFRESH;
          end else begin
            state_d = ST_IDLE;
            done    = 1'b1;
          end
        end
      end
      default: begin
        // Refresh states come on top of the configured waits.
        if (ref_cnt_q > 8'h1) begin
          ref_cnt_d = ref_cnt_q - 8'h1;
        end else begin
          refresh_d = 1'b0;
          state_d   = ST_IDLE;
          done      = 1'b1;
        end
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 2'h0;
      run_mode_q <= `WAIT_TWO;
      refresh_q  <= 1'b0;
      ref_cnt_q  <= 8'h00;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      run_mode_q <= run_mode_d;
      refresh_q  <= refresh_d;
      ref_cnt_q  <= ref_cnt_d;
    end
  end

  // ****************************************
  // Handshake outputs
  // ****************************************
  // wait_active decodes the state register; cycle_done comes combinationally from the next-state logic.
  assign wait_active = (state_q != ST_IDLE);
  assign cycle_done  = done;

endmodule

`default_nettype wire

// ---- sim/bus_size_wait_control_asserts.sv ----
// Checker for the area width and wait-state controller.
// Assumes the bench holds area matches steady over each bus cycle.
`timescale 1ns/1ns
`default_nettype none
module bus_size_wait_control_asserts #(
  parameter REFRESH_STATES = 3
) (
  input wire        sys_clk, rst_b, reg_wr, reg_rd, cycle_start, dram_access,
  input wire        refresh_collide, ext_width_select_pin, width_8bit,
  input wire        wait_active, cycle_done,
  input wire [7:0]  reg_rdata,
  input wire [23:0] bus_addr,
  input wire [3:0]  area_match, select_out_b,
  input wire [1:0]  wait_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire rf = dram_access & refresh_collide;
  // A start only counts once the selected settings have had a cycle to settle.
  sequence s_go;
    cycle_start && !wait_active && $stable(area_match) && !$past(reg_wr);
  endsequence
  a_zero_wait: assert property (
    s_go ##0 (wait_mode == 2'h3 && !rf) |-> cycle_done) else $error("zero-wait too long");
  a_one_wait: assert property (
    s_go ##0 (wait_mode == 2'h1 && !rf) |-> !cycle_done ##1 cycle_done)
    else $error("one-wait length wrong");
  a_two_wait: assert property (
    s_go ##0 (wait_mode == 2'h0 && !rf) |-> !cycle_done ##1 !cycle_done ##1 cycle_done)
    else $error("two-wait length wrong");
  a_pin_wait: assert property (
    s_go ##0 (wait_mode == 2'h2 && !rf) |-> !cycle_done ##[1:300] cycle_done)
    else $error("pin-wait length wrong");
  a_refresh_add: assert property (
    s_go ##0 (wait_mode == 2'h3 && rf) |-> !cycle_done ##REFRESH_STATES cycle_done)
    else $error("refresh length wrong");
  a_done_idle: assert property (cycle_done |=> !wait_active)
    else $error("wait still active after done");
  a_force_narrow: assert property (
    $past(rst_b) && $past(ext_width_select_pin) |-> width_8bit) else $error("width not forced");
  a_no_select: assert property (
    $past(rst_b) && $past(area_match) == 4'h0 && $past(bus_addr) < 24'h000080
    |-> select_out_b == 4'hF) else $error("select without match");
  a_single_select: assert property ($onehot0(~select_out_b))
    else $error("more than one select");
  a_read_zero: assert property ($past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero");
endmodule
bind bus_size_wait_control bus_size_wait_control_asserts #(
  .REFRESH_STATES(REFRESH_STATES)
) chk_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .cycle_start(cycle_start), .dram_access(dram_access), .refresh_collide(refresh_collide),
  .ext_width_select_pin(ext_width_select_pin), .width_8bit(width_8bit),
  .wait_active(wait_active), .cycle_done(cycle_done), .reg_rdata(reg_rdata),
  .bus_addr(bus_addr), .area_match(area_match), .select_out_b(select_out_b),
  .wait_mode(wait_mode)
);
`default_nettype wire

// ---- sim/wait_device.sv ----
// Model of a slow external device on the wait-request line.
// Assumes the bench sets how many cycles the device stays busy.
`timescale 1ns/1ns
`default_nettype none
module wait_device (
  // Clock and setting
  input  wire       sys_clk,
  input  wire [7:0] hold_cycles,
  // Wait-request pin, low while busy
  output logic      wait_req_b
);
  logic [7:0] left_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  // The line has a pull-up, so an idle device leaves it high.
  assign wait_req_b = (left_q == 8'h00);
  always @(posedge sys_clk) begin
    last_q <= hold_cycles;
    if (hold_cycles != last_q) begin
      left_q <= hold_cycles;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the area width and wait-state controller.
// Assumes the wait device model and the bound checker are compiled too.
`timescale 1ns/1ns
`default_nettype none
`include "bus_size_wait_defines.vh"
module testbench;
  logic        sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        cycle_start = 1'b0, dram_access = 1'b0, refresh_collide = 1'b0;
  logic        ext_width_select_pin = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, hold = 8'h00, reg_rdata;
  logic [23:0] bus_addr = 24'h000100;
  logic [3:0]  area_match = 4'h0, select_out_b;
  logic [1:0]  wait_mode;
  logic        area3_cas_mode, width_8bit, wait_active, cycle_done, wait_req_b;
  int          error_cnt = 0, total_checks = 0;
  int          lens [4] = '{2, 1, 1, 0};
  always #25 sys_clk = ~sys_clk;
  bus_size_wait_control #(.REFRESH_STATES(3)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_addr(bus_addr),
    .area_match(area_match), .cycle_start(cycle_start), .dram_access(dram_access),
    .refresh_collide(refresh_collide), .ext_width_select_pin(ext_width_select_pin),
    .wait_req_b(wait_req_b), .select_out_b(select_out_b),
    .area3_cas_mode(area3_cas_mode), .width_8bit(width_8bit), .wait_mode(wait_mode),
    .wait_active(wait_active), .cycle_done(cycle_done));
  wait_device dev_u (.sys_clk(sys_clk), .hold_cycles(hold), .wait_req_b(wait_req_b));
  task automatic summarize;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, 8'h00);
  endtask
  // Select, width and wait mode are packed into one byte for a single compare.
  task automatic look(input logic [3:0] sel, input logic w8, input logic [1:0] md);
    repeat (2) @(posedge sys_clk);
    #1 chk({select_out_b, 1'b0, width_8bit, wait_mode}, {sel, 1'b0, w8, md});
  endtask
  task automatic cyc(input int lo, input int hi);
    int n;
    @(posedge sys_clk) cycle_start <= 1'b1;
    #1 n = 0;
    while (cycle_done !== 1'b1 && n < 40) begin
      @(posedge sys_clk) cycle_start <= 1'b0;
      #1 n++;
    end
    if (n == 40) begin
      error_cnt++;
      summarize();
    end else begin
      chk({7'h00, wait_active}, 8'(lo > 0));
      chk(8'(n >= lo && n <= hi), 8'h01);
    end
    if (n == 0) begin
      @(posedge sys_clk) cycle_start <= 1'b0;
    end
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    look(4'hB, 1'b0, `WAIT_TWO);
    cyc(2, 2);
    rd(`AREA2_CTRL_ADDR);
    @(posedge sys_clk) area_match <= 4'h1;
    for (int m = 0; m < 4; m++) begin
      wr(`AREA0_CTRL_ADDR, 8'h10 | 8'(m));
      look(4'hE, 1'b0, 2'(m));
      cyc(lens[m], lens[m]);
    end
    wr(`AREA0_CTRL_ADDR, 8'h14);
    look(4'hE, 1'b1, `WAIT_TWO);
    wr(`AREA0_CTRL_ADDR, 8'h10);
    ext_width_select_pin <= 1'b1;
    look(4'hE, 1'b1, `WAIT_TWO);
    wr(`AREA1_CTRL_ADDR, 8'h13);
    ext_width_select_pin <= 1'b0;
    area_match <= 4'h3;
    look(4'hE, 1'b0, `WAIT_TWO);
    wr(`AREA0_CTRL_ADDR, 8'h03);
    look(4'hD, 1'b0, `WAIT_NONE);
    wr(`AREA3_CTRL_ADDR, 8'h18);
    area_match <= 4'h8;
    look(4'hB, 1'b0, `WAIT_TWO);
    wr(`AREA2_CTRL_ADDR, 8'h30);
    look(4'h7, 1'b0, `WAIT_TWO);
    chk({7'h00, area3_cas_mode}, 8'h01);
    wr(`UNMATCH_CTRL_ADDR, 8'h07);
    wr(8'h6D, 8'h10);
    area_match <= 4'h0;
    bus_addr <= 24'h000010;
    look(4'hF, 1'b1, `WAIT_NONE);
    wr(`AREA2_CTRL_ADDR, 8'h10);
    look(4'hF, 1'b1, `WAIT_NONE);
    @(posedge sys_clk) dram_access <= 1'b1;
    refresh_collide <= 1'b1;
    cyc(3, 3);
    wr(`UNMATCH_CTRL_ADDR, 8'h04);
    cyc(5, 5);
    wr(`UNMATCH_CTRL_ADDR, 8'h06);
    dram_access <= 1'b0;
    refresh_collide <= 1'b0;
    hold <= 8'h05;
    look(4'hF, 1'b1, `WAIT_ONE_PIN);
    cyc(3, 7);
    summarize();
  end
endmodule
`default_nettype wire
